/* File: core/imsd_top.sv */
// Status word, byte data path, read count and interrupt logic of a
// two-wire bus master. Assumes a shift engine on the same clock that
// reports its events as one-cycle pulses, and raw bus pin levels that
// arrive unsynchronised from the pads.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps

// What this block does
// - Bus occupied flag sets on start condition, clears on stop condition.
// - Receive overflow flag rises when a byte arrives at a full receive FIFO.
// - Transfer done flag sets when own transaction ends; may interrupt.
// - Data not-acknowledged flag sets on missing data acknowledge; may interrupt.
// - Master active flag high during own transaction, low if idle or bus lost.
// - Arbitration lost flag sets when bus control is not won; may interrupt.
// - Address not-acknowledged flag sets when no slave answers address; may interrupt.
// - Receive request flag set while received data sits in the FIFO.
// - Transmit request flag after address plus write, with zero or one byte queued.
// - Transmit FIFO level in bits 1:0: 00 empty, 01 one byte, 11 full.
// - Read-only 8-bit receive data register, reset value zero.
// - Write-only 8-bit transmit data register feeds bytes to send.
// - Read-write 16-bit read count register, reset value zero.
// - Low eight count bits hold bytes to read minus one.
// - Count bit 8 marks more than 256 bytes to read.
module imsd_top
  import imsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus pin levels
  input wire logic scl_i,
  input wire logic sda_i,
  // Shift engine side
  input wire logic eng_active_i,
  input wire logic eng_arb_lost_i,
  input wire logic eng_addr_nack_i,
  input wire logic eng_data_nack_i,
  input wire logic eng_addr_wr_sent_i,
  input wire logic eng_rx_valid_i,
  input wire logic [7:0] eng_rx_data_i,
  input wire logic eng_tx_pop_i,
  output logic eng_tx_valid_o,
  output logic [7:0] eng_tx_data_o,
  output logic [7:0] eng_rd_count_o,
  output logic eng_rd_count_ext_o,
  // Interrupt
  output logic irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  imsd_fifo_if tx_f ();
  imsd_fifo_if rx_f ();

  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_s3_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_s3_q;
  logic start_det;
  logic stop_det;

  logic bus_occupied_q;
  logic own_txn_q;
  logic active_d1_q;
  logic txn_begin;
  logic master_active_q;
  logic xfer_done_q;
  logic data_nack_q;
  logic addr_nack_q;
  logic arb_lost_q;
  logic rx_overflow_q;
  logic wr_phase_q;
  logic tx_request;
  logic tx_request_d1_q;
  logic rx_request;
  logic rx_overflow_evt;
  logic [1:0] tx_level;
  logic [15:0] status_w;

  logic [15:0] rd_count_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  imsd_wb_e wb_state_q;
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic [31:0] rd_mux;
  logic [31:0] dat_q;

  // ****************************************
  // Byte FIFOs
  // ****************************************
  imsd_fifo u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .f(tx_f.owner)
  );

  imsd_fifo u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .f(rx_f.owner)
  );

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  // Third stage only holds the previous settled level for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Data edges while the clock line stays high
  assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_occupied_q <= 1'b0;
    end else if (start_det) begin
      bus_occupied_q <= 1'b1;
    end else if (stop_det) begin
      bus_occupied_q <= 1'b0;
    end
  end

  // ****************************************
  // Transaction tracking
  // ****************************************
  assign txn_begin = eng_active_i && !active_d1_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_d1_q <= 1'b0;
    end else begin
      active_d1_q <= eng_active_i;
    end
  end

  // Own transaction lasts from engine activity until the stop on the wire
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_txn_q <= 1'b0;
    end else if (eng_active_i) begin
      own_txn_q <= 1'b1;
    end else if (stop_det) begin
      own_txn_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_active_q <= 1'b0;
    end else begin
      master_active_q <= eng_active_i && !eng_arb_lost_i && !arb_lost_q;
    end
  end

  // Sticky outcome flags last until the next transaction; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_done_q <= 1'b0;
    end else if (stop_det && own_txn_q) begin
      xfer_done_q <= 1'b1;
    end else if (txn_begin) begin
      xfer_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_nack_q <= 1'b0;
    end else if (eng_data_nack_i) begin
      data_nack_q <= 1'b1;
    end else if (txn_begin) begin
      data_nack_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_nack_q <= 1'b0;
    end else if (eng_addr_nack_i) begin
      addr_nack_q <= 1'b1;
    end else if (txn_begin) begin
      addr_nack_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb_lost_q <= 1'b0;
    end else if (eng_arb_lost_i) begin
      arb_lost_q <= 1'b1;
    end else if (txn_begin) begin
      arb_lost_q <= 1'b0;
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  assign rx_f.push = eng_rx_valid_i;
  assign rx_f.wdata = eng_rx_data_i;
  assign rx_f.pop = wb_rd && (wb_adr_i == ADR_RX_DATA);
  assign rx_overflow_evt = eng_rx_valid_i && rx_f.full;
  assign rx_request = !rx_f.empty;

  // Overflowing byte is dropped; flag falls at the next clean push or transaction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_overflow_q <= 1'b0;
    end else if (rx_overflow_evt) begin
      rx_overflow_q <= 1'b1;
    end else if (eng_rx_valid_i || txn_begin) begin
      rx_overflow_q <= 1'b0;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  assign tx_f.push = wb_wr && (wb_adr_i == ADR_TX_DATA) && wb_sel_i[0];
  assign tx_f.wdata = wb_dat_i[7:0];
  assign tx_f.pop = eng_tx_pop_i;
  assign eng_tx_valid_o = !tx_f.empty;
  assign eng_tx_data_o = tx_f.rdata;
  assign tx_level = imsd_tx_level(tx_f.count);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_phase_q <= 1'b0;
    end else if (eng_addr_wr_sent_i) begin
      wr_phase_q <= 1'b1;
    end else if (stop_det || txn_begin) begin
      wr_phase_q <= 1'b0;
    end
  end

  assign tx_request = wr_phase_q && (tx_f.count <= FIFO_ONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_request_d1_q <= 1'b0;
    end else begin
      tx_request_d1_q <= tx_request;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  always_comb begin
    status_w = STATUS_RESET;
    status_w[ST_BUS_OCCUPIED] = bus_occupied_q;
    status_w[ST_RX_OVERFLOW] = rx_overflow_q;
    status_w[ST_XFER_DONE] = xfer_done_q;
    status_w[ST_DATA_NACK] = data_nack_q;
    status_w[ST_MASTER_ACTIVE] = master_active_q;
    status_w[ST_ARB_LOST] = arb_lost_q;
    status_w[ST_ADDR_NACK] = addr_nack_q;
    status_w[ST_RX_REQUEST] = rx_request;
    status_w[ST_TX_REQUEST] = tx_request;
    status_w[ST_TX_LEVEL_LO +: 2] = tx_level;
  end

  // ****************************************
  // Read count register
  // ****************************************
  // Only count and extension bits are stored; upper bits read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_count_q <= RD_COUNT_RESET;
    end else if (wb_wr && (wb_adr_i == ADR_RD_COUNT)) begin
      if (wb_sel_i[0]) begin
        rd_count_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        rd_count_q[15:8] <= wb_dat_i[15:8] & RD_COUNT_MASK[15:8];
      end
    end
  end

  assign eng_rd_count_o = rd_count_q[7:0];
  assign eng_rd_count_ext_o = rd_count_q[RD_COUNT_EXT_BIT];

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irq_set = IRQ_RESET;
    irq_set[IRQ_DONE] = stop_det && own_txn_q;
    irq_set[IRQ_NACK] = eng_addr_nack_i || eng_data_nack_i;
    irq_set[IRQ_ARB] = eng_arb_lost_i;
    irq_set[IRQ_RX] = eng_rx_valid_i;
    irq_set[IRQ_TX] = tx_request && !tx_request_d1_q;
    irq_set[IRQ_OVF] = rx_overflow_evt;
  end

  assign irq_clr = (wb_wr && (wb_adr_i == ADR_IRQ_STATUS) && wb_sel_i[0]) ?
                   wb_dat_i[IRQ_W-1:0] : IRQ_RESET;

  // A set in the same cycle as its clear survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_q <= IRQ_RESET;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wb_wr && (wb_adr_i == ADR_IRQ_MASK) && wb_sel_i[0]) begin
      irq_mask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Every access is answered one cycle after it is seen, so one wait state
  assign wb_req = wb_cyc_i && wb_stb_i && (wb_state_q == WB_IDLE);
  assign wb_wr = wb_req && wb_we_i;
  assign wb_rd = wb_req && !wb_we_i;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      ADR_STATUS: begin
        rd_mux[15:0] = status_w;
      end
      ADR_RX_DATA: begin
        rd_mux[7:0] = rx_f.empty ? RX_DATA_RESET : rx_f.rdata;
      end
      ADR_RD_COUNT: begin
        rd_mux[15:0] = rd_count_q;
      end
      ADR_IRQ_STATUS: begin
        rd_mux[IRQ_W-1:0] = irq_status_q;
      end
      ADR_IRQ_MASK: begin
        rd_mux[IRQ_W-1:0] = irq_mask_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_q <= WB_IDLE;
    end else begin
      case (wb_state_q)
        WB_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            wb_state_q <= WB_ACK;
          end
        end
        WB_ACK: begin
          wb_state_q <= WB_IDLE;
        end
        default: begin
          wb_state_q <= WB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (wb_rd) begin
      dat_q <= rd_mux;
    end
  end

  assign wb_ack_o = (wb_state_q == WB_ACK);
  assign wb_dat_o = dat_q;

endmodule

/* File: core/imsd_pkg.sv */
// Shared constants for the two-wire master status and data block.
// Assumes a 32-bit classic Wishbone slave port and a 250 MHz system clock.
package imsd_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [31:0] ADR_STATUS = 32'hFFFF0904;
  localparam logic [31:0] ADR_RX_DATA = 32'hFFFF0908;
  localparam logic [31:0] ADR_TX_DATA = 32'hFFFF090C;
  localparam logic [31:0] ADR_RD_COUNT = 32'hFFFF0910;
  localparam logic [31:0] ADR_IRQ_STATUS = 32'hFFFF0980;
  localparam logic [31:0] ADR_IRQ_MASK = 32'hFFFF0984;

  // ****************************************
  // Status word layout
  // ****************************************
  localparam int ST_BUS_OCCUPIED = 10;
  localparam int ST_RX_OVERFLOW = 9;
  localparam int ST_XFER_DONE = 8;
  localparam int ST_DATA_NACK = 7;
  localparam int ST_MASTER_ACTIVE = 6;
  localparam int ST_ARB_LOST = 5;
  localparam int ST_ADDR_NACK = 4;
  localparam int ST_RX_REQUEST = 3;
  localparam int ST_TX_REQUEST = 2;
  localparam int ST_TX_LEVEL_LO = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ****************************************
  // Data and read count registers
  // ****************************************
  localparam logic [7:0] RX_DATA_RESET = 8'h00;
  localparam logic [15:0] RD_COUNT_RESET = 16'h0000;
  localparam logic [15:0] RD_COUNT_MASK = 16'h01FF;
  localparam int RD_COUNT_EXT_BIT = 8;

  // ****************************************
  // Transmit FIFO level codes
  // ****************************************
  localparam logic [1:0] TX_LEVEL_EMPTY = 2'b00;
  localparam logic [1:0] TX_LEVEL_ONE = 2'b01;
  localparam logic [1:0] TX_LEVEL_FULL = 2'b11;

  // ****************************************
  // FIFO shape
  // ****************************************
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 2;
  localparam int FIFO_CNT_W = 2;
  localparam logic [FIFO_CNT_W-1:0] FIFO_ONE = 2'h1;

  // ****************************************
  // Interrupt status and mask layout
  // ****************************************
  localparam int IRQ_W = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  localparam int IRQ_ARB = 2;
  localparam int IRQ_RX = 3;
  localparam int IRQ_TX = 4;
  localparam int IRQ_OVF = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

  typedef enum logic [0:0] {
    WB_IDLE = 1'b0,
    WB_ACK = 1'b1
  } imsd_wb_e;

  // Maps an occupancy count to the two-bit level code
  function automatic logic [1:0] imsd_tx_level(input logic [FIFO_CNT_W-1:0] cnt);
    logic [1:0] lvl;
    lvl = TX_LEVEL_EMPTY;
    if (cnt >= 2'(FIFO_DEPTH)) begin
      lvl = TX_LEVEL_FULL;
    end else if (cnt != '0) begin
      lvl = TX_LEVEL_ONE;
    end
    return lvl;
  endfunction

endpackage

/* File: core/imsd_fifo_if.sv */
// Connection bundle between the main block and one byte FIFO.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface imsd_fifo_if;
  import imsd_pkg::*;
  logic push;
  logic [FIFO_WIDTH-1:0] wdata;
  logic pop;
  logic [FIFO_WIDTH-1:0] rdata;
  logic [FIFO_CNT_W-1:0] count;
  logic full;
  logic empty;
  modport owner(input push, input wdata, input pop,
                output rdata, output count, output full, output empty);
  modport user(output push, output wdata, output pop,
               input rdata, input count, input full, input empty);
endinterface

/* File: core/imsd_fifo.sv */
// Small byte FIFO used for both the transmit and the receive path.
// Assumes a synchronous active-high reset; a push while full is dropped.
`timescale 1ns/1ps
module imsd_fifo
  import imsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  imsd_fifo_if.owner f
);

  localparam int PW = $clog2(FIFO_DEPTH);

  logic [FIFO_WIDTH-1:0] mem_q [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [FIFO_CNT_W-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  assign f.full = (cnt_q == FIFO_CNT_W'(FIFO_DEPTH));
  assign f.empty = (cnt_q == '0);
  assign f.count = cnt_q;
  assign f.rdata = mem_q[rd_ptr_q];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_q[i] <= RX_DATA_RESET;
      end
    end else if (do_push) begin
      mem_q[wr_ptr_q] <= f.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
      end
      if (do_pop) begin
        rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (do_push && !do_pop) begin
      cnt_q <= cnt_q + FIFO_ONE;
    end else if (do_pop && !do_push) begin
      cnt_q <= cnt_q - FIFO_ONE;
    end
  end

endmodule

/* File: tb/imsd_asserts.sv */
// Concurrent checks on the ports of imsd_top.
// Assumes a classic Wishbone master that drops stb between cycles.
`timescale 1ns/1ps
module imsd_asserts
  import imsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic eng_active_i,
  input wire logic eng_arb_lost_i,
  input wire logic eng_addr_nack_i,
  input wire logic eng_data_nack_i,
  input wire logic eng_addr_wr_sent_i,
  input wire logic eng_rx_valid_i,
  input wire logic [7:0] eng_rx_data_i,
  input wire logic eng_tx_pop_i,
  input wire logic eng_tx_valid_o,
  input wire logic [7:0] eng_tx_data_o,
  input wire logic [7:0] eng_rd_count_o,
  input wire logic eng_rd_count_ext_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Bus cycle shapes
  // ****************************************
  sequence s_take;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_tx_wr;
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_TX_DATA);
  endsequence
  sequence s_cnt_rd;
    s_take ##0 (!wb_we_i && wb_adr_i == ADR_RD_COUNT);
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_ack_latency: assert property (s_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_tx_push: assert property (s_tx_wr ##0 !eng_tx_valid_o |=>
    eng_tx_valid_o && eng_tx_data_o == $past(wb_dat_i[7:0]))
    else $error("written byte not at transmit head");
  a_tx_hold: assert property (eng_tx_valid_o && !eng_tx_pop_i |=> eng_tx_valid_o)
    else $error("transmit byte lost without pop");
  a_tx_wr_only: assert property (s_take ##0 (!wb_we_i && wb_adr_i == ADR_TX_DATA)
    |=> wb_dat_o == 32'h0)
    else $error("transmit data readable");
  a_cnt_write: assert property (s_take ##0 (wb_we_i && wb_adr_i == ADR_RD_COUNT
    && wb_sel_i == 4'hF) |=> {eng_rd_count_ext_o, eng_rd_count_o} == $past(wb_dat_i[8:0]))
    else $error("read count not stored");
  a_cnt_read: assert property (s_cnt_rd
    |=> wb_dat_o == {23'h0, eng_rd_count_ext_o, eng_rd_count_o})
    else $error("read count readback differs");
  a_status_rsvd: assert property (s_take ##0 (!wb_we_i && wb_adr_i == ADR_STATUS)
    |=> wb_dat_o[31:11] == 21'h0 && wb_dat_o[1:0] != 2'b10)
    else $error("status reserved bits or level code wrong");
  a_irq_reset: assert property ($fell(rst_i) |-> !irq_o)
    else $error("interrupt high after reset");
endmodule

bind imsd_top imsd_asserts i_imsd_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .sda_i(sda_i),
  .eng_active_i(eng_active_i), .eng_arb_lost_i(eng_arb_lost_i),
  .eng_addr_nack_i(eng_addr_nack_i), .eng_data_nack_i(eng_data_nack_i),
  .eng_addr_wr_sent_i(eng_addr_wr_sent_i), .eng_rx_valid_i(eng_rx_valid_i),
  .eng_rx_data_i(eng_rx_data_i), .eng_tx_pop_i(eng_tx_pop_i), .eng_tx_valid_o(eng_tx_valid_o),
  .eng_tx_data_o(eng_tx_data_o), .eng_rd_count_o(eng_rd_count_o),
  .eng_rd_count_ext_o(eng_rd_count_ext_o), .irq_o(irq_o));

/* File: tb/imsd_partner.sv */
// Far side model: bus pin levels plus the shift engine's events.
// Assumes the bench calls its tasks from one clocked sequence.
`timescale 1ns/1ps
module imsd_partner (
  input wire logic clk_i,
  output logic scl_o = 1'b1,
  output logic sda_o = 1'b1,
  output logic act_o = 1'b0,
  output logic [5:0] ev_o = 6'h00,
  output logic [7:0] rxd_o = 8'h00
);
  logic lclk = 1'b1;
  logic frame = 1'b0;
  // ****************************************
  // Link clock, still outside frames
  // ****************************************
  always #62.5 lclk = ~lclk;
  always @(posedge clk_i) begin
    scl_o <= frame ? lclk : 1'b1;
  end
  // ****************************************
  // Conditions and events
  // ****************************************
  task start_cond;
    @(posedge clk_i);
    sda_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    frame <= 1'b1;
  endtask
  // Data stays low inside a frame so no false condition is seen
  task stop_cond;
    @(posedge clk_i);
    frame <= 1'b0;
    repeat (8) @(posedge clk_i);
    sda_o <= 1'b1;
  endtask
  task ev(input int k, input logic [7:0] d);
    @(posedge clk_i);
    rxd_o <= d;
    ev_o <= 6'(1 << k);
    @(posedge clk_i);
    ev_o <= 6'h00;
    rxd_o <= ~d;
  endtask
  task act(input logic b);
    @(posedge clk_i);
    act_o <= b;
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for imsd_top built on Wishbone register tasks.
// Assumes imsd_partner drives the bus pins and the engine event pulses.
`timescale 1ns/1ps
module tb_top
  import imsd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [7:0] txd, rxd, cnt;
  logic [5:0] ev;
  logic wb_ack_o, scl, sda, act, irq_o, txv, ext;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [31:0] RST_ADR [6] = '{ADR_STATUS, ADR_RX_DATA, ADR_TX_DATA,
    ADR_RD_COUNT, ADR_IRQ_STATUS, ADR_IRQ_MASK};
  always #2 clk_i = ~clk_i;
  imsd_partner far (.clk_i(clk_i), .scl_o(scl), .sda_o(sda), .act_o(act), .ev_o(ev),
    .rxd_o(rxd));
  imsd_top i_imsd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .sda_i(sda), .eng_active_i(act),
    .eng_arb_lost_i(ev[0]), .eng_addr_nack_i(ev[1]), .eng_data_nack_i(ev[2]),
    .eng_addr_wr_sent_i(ev[3]), .eng_rx_valid_i(ev[4]), .eng_rx_data_i(rxd),
    .eng_tx_pop_i(ev[5]), .eng_tx_valid_o(txv), .eng_tx_data_o(txd), .eng_rd_count_o(cnt),
    .eng_rd_count_ext_o(ext), .irq_o(irq_o));
  // ****************************************
  // Tasks
  // ****************************************
  task results;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      err_count++;
    end
  endtask
  // Holds the request until ack is sampled, then releases it
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // No answer time is assumed; if ack never comes, only the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task irq(input logic e);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(RST_ADR[i], 32'hFFFFFFFF, 32'h0);
    irq(1'b0);
    wr(ADR_RD_COUNT, 32'h0000FFFF);
    rd(ADR_RD_COUNT, 32'hFFFFFFFF, 32'h000001FF);
    wr(ADR_RD_COUNT, 32'h00000100);
    chk({23'h0, ext, cnt}, 32'h00000100);
    wr(32'hFFFF0A00, 32'hFFFFFFFF);
    rd(32'hFFFF0A00, 32'hFFFFFFFF, 32'h0);
    wr(ADR_IRQ_MASK, 32'h0000003F);
    far.start_cond();
    repeat (8) @(posedge clk_i);
    rd(ADR_STATUS, 32'h00000400, 32'h00000400);
    far.act(1'b1);
    rd(ADR_STATUS, 32'h00000047, 32'h00000040);
    far.ev(3, 8'h00);
    rd(ADR_STATUS, 32'h00000007, 32'h00000004);
    wr(ADR_TX_DATA, 32'h000000A5);
    rd(ADR_STATUS, 32'h00000007, 32'h00000005);
    wr(ADR_TX_DATA, 32'h0000005A);
    rd(ADR_STATUS, 32'h00000007, 32'h00000003);
    wr(ADR_TX_DATA, 32'h000000C3);
    chk({24'h0, txd}, 32'h000000A5);
    far.ev(5, 8'h00);
    @(posedge clk_i);
    chk({24'h0, txd}, 32'h0000005A);
    far.ev(5, 8'h00);
    @(posedge clk_i);
    chk({31'h0, txv}, 32'h0);
    far.ev(2, 8'h00);
    rd(ADR_STATUS, 32'h00000080, 32'h00000080);
    far.act(1'b0);
    far.stop_cond();
    repeat (8) @(posedge clk_i);
    rd(ADR_STATUS, 32'h00000544, 32'h00000100);
    rd(ADR_IRQ_STATUS, 32'h0000003F, 32'h00000013);
    irq(1'b1);
    wr(ADR_IRQ_MASK, 32'h0);
    irq(1'b0);
    wr(ADR_IRQ_MASK, 32'h0000003F);
    wr(ADR_IRQ_STATUS, 32'h0000003F);
    irq(1'b0);
    far.start_cond();
    far.act(1'b1);
    rd(ADR_STATUS, 32'h00000180, 32'h0);
    far.ev(1, 8'h00);
    far.ev(0, 8'h00);
    rd(ADR_STATUS, 32'h00000070, 32'h00000030);
    far.ev(4, 8'h11);
    far.ev(4, 8'h22);
    rd(ADR_STATUS, 32'h00000208, 32'h00000008);
    far.ev(4, 8'h33);
    rd(ADR_STATUS, 32'h00000200, 32'h00000200);
    rd(ADR_RX_DATA, 32'hFFFFFFFF, 32'h00000011);
    rd(ADR_RX_DATA, 32'hFFFFFFFF, 32'h00000022);
    rd(ADR_RX_DATA, 32'hFFFFFFFF, 32'h0);
    far.ev(4, 8'h55);
    rd(ADR_STATUS, 32'h00000200, 32'h0);
    rd(ADR_RX_DATA, 32'hFFFFFFFF, 32'h00000055);
    rd(ADR_IRQ_STATUS, 32'h0000003F, 32'h0000002E);
    irq(1'b1);
    wr(ADR_IRQ_STATUS, 32'h0000003F);
    rd(ADR_IRQ_STATUS, 32'h0000003F, 32'h0);
    far.act(1'b0);
    far.stop_cond();
    results();
  end
endmodule
